// [inc/csf_pkg.sv]
`default_nettype none
// ----------------------------------------------------------------
// Status flag register: shared constants and carriers
// ----------------------------------------------------------------
package csf_pkg;

    // Register map, byte addresses on the bus
    localparam logic [3:0] CSF_OFS_STATUS = 4'h0;
    localparam logic [3:0] CSF_OFS_BANK   = 4'h4;

    // Field positions inside the status byte
    localparam int CSF_BIT_C        = 0;
    localparam int CSF_BIT_NIB      = 1;
    localparam int CSF_BIT_Z        = 2;
    localparam int CSF_BIT_SLP      = 3;
    localparam int CSF_BIT_TO       = 4;
    localparam int CSF_BIT_BANK_LO  = 5;
    localparam int CSF_BIT_BANK_HI  = 6;
    localparam int CSF_BIT_BANK_IND = 7;

    // Bits a plain write may change (bank and ALU flags only)
    localparam logic [7:0] CSF_WR_MASK   = 8'hE7;
    // Bits an instruction flag update replaces
    localparam logic [7:0] CSF_FLAG_MASK = 8'h07;
    // Value after reset: time-out and sleep flags set, the rest clear
    localparam logic [7:0] CSF_RST_VAL   = 8'h18;

    // Core operations presented to the block
    typedef enum logic [3:0] {
        CSF_OP_NONE  = 4'b0000, // No operation
        CSF_OP_PLAIN = 4'b0001, // Write, no flags (move, bit ops, swap)
        CSF_OP_ADD   = 4'b0010, // file/literal plus W
        CSF_OP_SUB   = 4'b0011, // file/literal minus W
        CSF_OP_AND   = 4'b0100, // Logic and
        CSF_OP_IOR   = 4'b0101, // Logic or
        CSF_OP_XOR   = 4'b0110, // Logic xor
        CSF_OP_MOVE  = 4'b0111, // Move file, zero flag only
        CSF_OP_ROTL  = 4'b1000, // Rotate left through carry
        CSF_OP_ROTR  = 4'b1001, // Rotate right through carry
        CSF_OP_CLR   = 4'b1010  // File clear
    } csf_op_t;

    // One executed instruction from the core
    typedef struct packed {
        logic       valid;       // Instruction executes this cycle
        csf_op_t    op;          // Operation
        logic [7:0] opa;         // W register or plain write data
        logic [7:0] opb;         // File or literal operand
        logic       dest_status; // Result goes to the status register
    } csf_core_req_t;

    // Watchdog and sleep events, one-cycle pulses
    typedef struct packed {
        logic wdog_clear;  // Watchdog clear instruction
        logic sleep;       // Sleep instruction
        logic wdog_expire; // Watchdog timer expired
    } csf_events_t;

endpackage
`default_nettype wire

// [verilog/csf_status_reg.sv]
// Overview of operation
// R01 - Status register accepts instruction writes like any file register.
// R02 - Status destination: ALU values override written zero/nibble/carry.
// R03 - Time-out and power-down flags ignore all instruction writes.
// R04 - File clear of status zeroes upper three bits and sets zero flag.
// R05 - Software should alter status only by bit, swap and move ops.
// R06 - Software keeps the two upper reserved bank bits cleared.
// R07 - Bank select bit picks bank 1 (80h-FFh) or bank 0 (00h-7Fh).
// R08 - Time-out set on power-up, watchdog clear or sleep; cleared on expiry.
// R09 - Power-down flag sets on power-up or watchdog clear; clears on sleep.
// R10 - Zero flag set when result is zero, cleared otherwise.
// R11 - Nibble carry set on carry out of bit 3 for add and subtract.
// R12 - Carry set on carry out of bit 7 for add and subtract.
// R13 - Subtraction adds the two's complement of the second operand.
// R14 - Rotates load carry with the bit shifted out.
// R15 - Reset: bank select 0, time-out and power-down 1.
`default_nettype none
module csf_status_reg (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // Core instruction port
    input  wire csf_pkg::csf_core_req_t core_req,
    input  wire csf_pkg::csf_events_t   core_evt,
    input  wire logic [6:0]            dir_addr,
    // Results to the core
    output logic      [7:0]            alu_result,
    output logic                       alu_valid,
    output logic      [7:0]            status_out,
    output logic      [7:0]            data_addr
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------

    // Status bits except time-out and sleep
    logic [7:0] status;
    // Time-out and sleep flags kept apart, no write path reaches them
    logic       watchdog_expired_flag;
    logic       sleep_entered_flag;
    logic [7:0] status_view;
    logic [7:0] next_status;

    // ALU working values
    logic [7:0] opnd_y;
    logic       carry_in;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] result;
    logic       flag_z;
    logic       flag_dc;
    logic       flag_c;
    logic       upd_z;
    logic       upd_dc;
    logic       upd_c;

    // Bus decode
    logic       bus_req;
    logic       bus_commit;
    logic       hit_status;
    logic       hit_bank;
    logic       core_wr;
    // Operation present, flags touched, bank bit view
    logic       core_op;
    logic       flag_op;
    logic       bank_sel;

    // ------------------------------------------------------------
    // Composite view of the status byte
    // ------------------------------------------------------------

    // Merge time-out and sleep flags into their positions
    always_comb begin
        status_view = status;
        status_view[csf_pkg::CSF_BIT_TO]  = watchdog_expired_flag;
        status_view[csf_pkg::CSF_BIT_SLP] = sleep_entered_flag;
    end

    // ------------------------------------------------------------
    // Arithmetic for add and subtract
    // ------------------------------------------------------------

    // Subtract adds the inverted W plus one
    always_comb begin
        if (core_req.op == csf_pkg::CSF_OP_SUB) begin
            opnd_y   = ~core_req.opa; // R13
            carry_in = 1'b1;          // R13
        end else begin
            opnd_y   = core_req.opa;
            carry_in = 1'b0;
        end
    end

    // Full sum and low nibble sum with carries
    assign sum9 = {1'b0, core_req.opb} + {1'b0, opnd_y}
                + {8'h00, carry_in};
    assign sum5 = {1'b0, core_req.opb[3:0]} + {1'b0, opnd_y[3:0]}
                + {4'h0, carry_in};

    // ------------------------------------------------------------
    // Result and flags per operation
    // ------------------------------------------------------------

    // Select result, new flags and which flags change
    always_comb begin
        result  = core_req.opa;
        flag_c  = status[csf_pkg::CSF_BIT_C];
        flag_dc = sum5[4];
        upd_z   = 1'b0;
        upd_dc  = 1'b0;
        upd_c   = 1'b0;
        case (core_req.op)
            csf_pkg::CSF_OP_PLAIN: begin
                result = core_req.opa;
            end
            csf_pkg::CSF_OP_ADD,
            csf_pkg::CSF_OP_SUB: begin
                result = sum9[7:0];
                flag_c = sum9[8];   // R12
                upd_z  = 1'b1;
                upd_dc = 1'b1;      // R11
                upd_c  = 1'b1;      // R12
            end
            csf_pkg::CSF_OP_AND: begin
                result = core_req.opa & core_req.opb;
                upd_z  = 1'b1;
            end
            csf_pkg::CSF_OP_IOR: begin
                result = core_req.opa | core_req.opb;
                upd_z  = 1'b1;
            end
            csf_pkg::CSF_OP_XOR: begin
                result = core_req.opa ^ core_req.opb;
                upd_z  = 1'b1;
            end
            csf_pkg::CSF_OP_MOVE: begin
                result = core_req.opb;
                upd_z  = 1'b1;
            end
            csf_pkg::CSF_OP_ROTL: begin
                result = {core_req.opb[6:0],
                          status[csf_pkg::CSF_BIT_C]};
                flag_c = core_req.opb[7]; // R14
                upd_c  = 1'b1;
            end
            csf_pkg::CSF_OP_ROTR: begin
                result = {status[csf_pkg::CSF_BIT_C],
                          core_req.opb[7:1]};
                flag_c = core_req.opb[0]; // R14
                upd_c  = 1'b1;
            end
            csf_pkg::CSF_OP_CLR: begin
                result = 8'h00; // R04
                upd_z  = 1'b1;
            end
            default: begin
                result = core_req.opa;
            end
        endcase
    end

    // Zero flag from the result
    assign flag_z = (result == 8'h00); // R10

    // Operation touches at least one ALU flag
    assign flag_op = upd_z | upd_dc | upd_c;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------

    // Request seen; commit on the cycle that carries the ack
    assign bus_req    = wb_cyc_i & wb_stb_i;
    assign bus_commit = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign hit_status = (wb_adr_i == csf_pkg::CSF_OFS_STATUS);
    assign hit_bank   = (wb_adr_i == csf_pkg::CSF_OFS_BANK);
    // Instruction that changes state this cycle
    assign core_op    = core_req.valid
                      & (core_req.op != csf_pkg::CSF_OP_NONE);
    assign core_wr    = core_op & core_req.dest_status;
    // Bank select as seen by addressing and the bus
    assign bank_sel   = status[csf_pkg::CSF_BIT_BANK_LO];

    // ------------------------------------------------------------
    // Next value of the writable bits
    // ------------------------------------------------------------

    // Core write first, flags over it, bus only when the core does not write status
    always_comb begin
        next_status = status;
        if (core_wr) begin
            // Any op may target status like a file register
            next_status = (status & ~csf_pkg::CSF_WR_MASK)
                        | (result & csf_pkg::CSF_WR_MASK); // R01
            // Write to flags suppressed when op affects flags
            if (flag_op) begin // R02
                next_status[csf_pkg::CSF_BIT_Z] =
                    status[csf_pkg::CSF_BIT_Z];
                next_status[csf_pkg::CSF_BIT_NIB] =
                    status[csf_pkg::CSF_BIT_NIB];
                next_status[csf_pkg::CSF_BIT_C] =
                    status[csf_pkg::CSF_BIT_C];
            end
        end else if (bus_commit & hit_status) begin
            // Bus write to the status byte
            next_status = (status & ~csf_pkg::CSF_WR_MASK)
                        | (wb_dat_i[7:0] & csf_pkg::CSF_WR_MASK);
        end else if (bus_commit & hit_bank) begin
            // Bus write to the bank alias
            next_status[csf_pkg::CSF_BIT_BANK_LO] = wb_dat_i[0];
        end
        // Affected flags take the ALU values
        if (core_req.valid) begin
            if (upd_z) begin
                next_status[csf_pkg::CSF_BIT_Z] = flag_z; // R02
            end
            if (upd_dc) begin
                next_status[csf_pkg::CSF_BIT_NIB] = flag_dc; // R02
            end
            if (upd_c) begin
                next_status[csf_pkg::CSF_BIT_C] = flag_c; // R02
            end
        end
        // Time-out and sleep flags never written here
        next_status[csf_pkg::CSF_BIT_TO]  = 1'b0; // R03
        next_status[csf_pkg::CSF_BIT_SLP] = 1'b0; // R03
    end

    // ------------------------------------------------------------
    // Status storage
    // ------------------------------------------------------------

    // Bank, reserved and ALU flag bits
    always_ff @(posedge clk) begin
        if (srst) begin
            status <= csf_pkg::CSF_RST_VAL
                    & csf_pkg::CSF_WR_MASK; // R15
        end else begin
            status <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Time-out and sleep flags
    // ------------------------------------------------------------

    // Time-out flag: set by clear or sleep, expiry wins
    always_ff @(posedge clk) begin
        if (srst) begin
            watchdog_expired_flag <= 1'b1; // R15
        end else if (core_evt.wdog_expire) begin
            watchdog_expired_flag <= 1'b0; // R08
        end else if (core_evt.wdog_clear | core_evt.sleep) begin
            watchdog_expired_flag <= 1'b1; // R08
        end
    end

    // Power-down flag: cleared by sleep, set by watchdog clear
    always_ff @(posedge clk) begin
        if (srst) begin
            sleep_entered_flag <= 1'b1; // R15
        end else if (core_evt.sleep) begin
            sleep_entered_flag <= 1'b0; // R09
        end else if (core_evt.wdog_clear) begin
            sleep_entered_flag <= 1'b1; // R09
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // Read data captured with the ack, unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req & ~wb_ack_o) begin
            if (hit_status) begin
                wb_dat_o <= {24'h00_0000, status_view};
            end else if (hit_bank) begin
                wb_dat_o <= {31'h0000_0000,
                             bank_sel};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs to the core
    // ------------------------------------------------------------

    // Registered ALU result and its strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            alu_result <= 8'h00;
            alu_valid  <= 1'b0;
        end else begin
            alu_result <= result;
            // Strobe for any real operation
            alu_valid  <= core_op;
        end
    end

    // Registered status copy
    always_ff @(posedge clk) begin
        if (srst) begin
            status_out <= csf_pkg::CSF_RST_VAL;
        end else begin
            status_out <= status_view;
        end
    end

    // Direct address: bank bit above the 7-bit offset
    always_ff @(posedge clk) begin
        if (srst) begin
            data_addr <= 8'h00;
        end else begin
            data_addr <= {bank_sel,
                          dir_addr}; // R07
        end
    end

endmodule
`default_nettype wire

// [bench/csf_status_reg_properties.sv]
`default_nettype none
module csf_status_reg_properties (
    // Clock, reset and bus
    input wire logic                    clk,
    input wire logic                    srst,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [3:0]              wb_adr_i,
    input wire logic [3:0]              wb_sel_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    // Core side
    input wire csf_pkg::csf_core_req_t  core_req,
    input wire csf_pkg::csf_events_t    core_evt,
    input wire logic [6:0]              dir_addr,
    input wire logic [7:0]              alu_result,
    input wire logic                    alu_valid,
    input wire logic [7:0]              status_out,
    input wire logic [7:0]              data_addr
);
    timeunit 1ns;
    timeprecision 1ns;

    // -------------------------------------------------------------
    // Expected carries from the operands on the core port
    // -------------------------------------------------------------
    logic [8:0] add_s;
    logic [8:0] sub_s;
    logic [4:0] add_n;
    logic [4:0] sub_n;
    assign add_s = {1'b0, core_req.opb} + {1'b0, core_req.opa};
    assign sub_s = {1'b0, core_req.opb} + {1'b0, ~core_req.opa} + 9'h001;
    assign add_n = {1'b0, core_req.opb[3:0]} + {1'b0, core_req.opa[3:0]};
    assign sub_n = {1'b0, core_req.opb[3:0]} + {1'b0, ~core_req.opa[3:0]}
                   + 5'h01;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // -------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------
    AST_RST_VAL: assert property ($fell(srst) |-> status_out == 8'h18)
        else $error("status not at reset value");
    AST_ADD_FLAGS: assert property (core_req.valid && core_req.op ==
        csf_pkg::CSF_OP_ADD |-> ##2 status_out[1:0] == $past({add_n[4],
        add_s[8]}, 2)) else $error("add carries wrong");
    AST_SUB_FLAGS: assert property (core_req.valid && core_req.op ==
        csf_pkg::CSF_OP_SUB |-> ##2 status_out[1:0] == $past({sub_n[4],
        sub_s[8]}, 2)) else $error("sub borrows wrong");
    AST_ROT_LEFT: assert property (core_req.valid && core_req.op ==
        csf_pkg::CSF_OP_ROTL |-> ##2 status_out[0] == $past(core_req.opb[7],
        2)) else $error("rotate carry wrong");
    AST_ZERO: assert property (core_req.valid && core_req.op inside {
        csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_XOR} |-> ##1 alu_valid ##1
        status_out[2] == ($past(alu_result) == 8'h00)) else $error("zero");
    AST_CLEAR: assert property (core_req.valid && core_req.dest_status &&
        core_req.op == csf_pkg::CSF_OP_CLR |-> ##2 {status_out[7:5],
        status_out[2]} == 4'h1) else $error("clear of status wrong");
    AST_EXPIRE: assert property (core_evt.wdog_expire |-> ##2
        !status_out[4]) else $error("time-out flag not cleared");
    AST_KEEP_TOPD: assert property (core_evt == 3'h0 |-> ##2
        $stable(status_out[4:3])) else $error("flags moved with no event");
    AST_BANK_ADDR: assert property (!$past(srst) |-> data_addr ==
        {status_out[5], $past(dir_addr)}) else $error("bank address wrong");

    // Main scenarios
    cover property (core_req.valid && core_req.dest_status);
    cover property (wb_ack_o && wb_we_i);
    cover property (core_evt.sleep);
endmodule

bind csf_status_reg csf_status_reg_properties u_props (.clk, .srst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .core_req, .core_evt, .dir_addr, .alu_result,
    .alu_valid, .status_out, .data_addr);
`default_nettype wire

// [bench/csf_core_model.sv]
`default_nettype none
module csf_core_model (
    // Clock
    input  wire logic                    clk,
    // Instruction and event outputs
    output var csf_pkg::csf_core_req_t   core_req,
    output var csf_pkg::csf_events_t     core_evt
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        core_req = '0;
        core_evt = '0;
    end

    // One instruction, then operands no longer hold their value
    task automatic exec(input csf_pkg::csf_op_t o, input logic [7:0] a,
                        input logic [7:0] b, input logic d);
        core_req <= '{1'b1, o, a, b, d};
        @(posedge clk);
        core_req <= '{1'b0, csf_pkg::CSF_OP_NONE, ~a, ~b, 1'b0};
    endtask

    // One-cycle watchdog and sleep events
    task automatic pulse(input logic [2:0] e);
        core_evt <= e;
        @(posedge clk);
        core_evt <= '0;
    endtask
endmodule
`default_nettype wire

// [bench/csf_status_reg_bench.sv]
`default_nettype none
module csf_status_reg_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // Wires and model state
    logic                    clk;
    logic                    srst;
    logic                    wb_cyc;
    logic                    wb_stb;
    logic                    wb_we;
    logic                    wb_ack;
    logic                    alu_valid;
    logic [3:0]              wb_adr;
    logic [31:0]             wb_dat;
    logic [31:0]             wb_q;
    logic [6:0]              dir_addr;
    logic [7:0]              alu_result;
    logic [7:0]              status_out;
    logic [7:0]              data_addr;
    logic [7:0]              q;
    csf_pkg::csf_core_req_t  core_req;
    csf_pkg::csf_events_t    core_evt;
    int                      n_errors = 0;
    int                      tests_run = 0;
    int                      st = 'h18;
    int unsigned             x = 576;

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    csf_core_model u_core (.clk(clk), .core_req(core_req),
                           .core_evt(core_evt));
    csf_status_reg u_dut (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
        .wb_ack_o(wb_ack), .core_req(core_req), .core_evt(core_evt),
        .dir_addr(dir_addr), .alu_result(alu_result),
        .alu_valid(alu_valid), .status_out(status_out),
        .data_addr(data_addr));

    // Random source
    function automatic int unsigned rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Compare one byte
    task automatic chk(string nm, int e, logic [7:0] g);
        tests_run++;
        if (g !== 8'(e)) begin
            $display("[FAIL] %s expected %h seen %h", nm, 8'(e), g);
            n_errors++;
        end
    endtask

    // Classic single Wishbone cycle, then one idle cycle
    task automatic wb(logic we, logic [3:0] a, logic [7:0] d);
        int k;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= {24'h0, d};
        for (k = 0; k < 20 && wb_ack !== 1'b1; k++) @(posedge clk);
        if (wb_ack !== 1'b1) begin
            n_errors++;
            conclude();
        end
        q = wb_q[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
        if (we && a == 4'h0) st = st & 'h18 | d & 'hE7;
        if (we && a == 4'h4) st = st & 'hDF | (d & 1) << 5;
    endtask

    // Read back the status, bank and unmapped places
    task automatic rd_all();
        wb(1'b0, 4'h0, 8'h00);
        chk("status", st, q);
        wb(1'b0, 4'h4, 8'h00);
        chk("bank", st >> 5 & 1, q);
        wb(1'b0, 4'h8, 8'h00);
        chk("unmapped", 0, q);
    endtask

    // One instruction through the core model and the byte model
    task automatic run(csf_pkg::csf_op_t o, logic [7:0] a, logic [7:0] b,
                       logic d, int dv);
        int s, n, c, z, old;
        old = st;
        c = st & 1;
        n = st >> 1 & 1;
        z = st >> 2 & 1;
        case (o)
            csf_pkg::CSF_OP_ADD: begin
                s = b + a;
                n = ((b & 15) + (a & 15)) >> 4;
                c = s >> 8 & 1;
            end
            csf_pkg::CSF_OP_SUB: begin
                s = b + (~a & 255) + 1;
                n = ((b & 15) + (~a & 15) + 1) >> 4;
                c = s >> 8 & 1;
            end
            csf_pkg::CSF_OP_AND: s = b & a;
            csf_pkg::CSF_OP_IOR: s = b | a;
            csf_pkg::CSF_OP_XOR: s = b ^ a;
            csf_pkg::CSF_OP_MOVE: s = b;
            csf_pkg::CSF_OP_CLR: s = 0;
            csf_pkg::CSF_OP_ROTL: begin
                s = (b << 1 | c) & 255;
                c = b >> 7 & 1;
            end
            csf_pkg::CSF_OP_ROTR: begin
                s = b >> 1 | c << 7;
                c = b & 1;
            end
            default: s = a;
        endcase
        s = s & 255;
        if (o inside {[csf_pkg::CSF_OP_ADD:csf_pkg::CSF_OP_MOVE],
                      csf_pkg::CSF_OP_CLR}) z = s == 0;
        if (d) st = st & 'h18 | s & 'hE7;
        if (o != csf_pkg::CSF_OP_PLAIN) st = st & 'hF8 | z << 2 | n << 1 | c;
        u_core.exec(o, a, b, d);
        #1;
        chk("alu_result", s, alu_result);
        chk("alu_valid", 1, {7'h0, alu_valid});
        @(posedge clk);
        #1;
        chk("status_out", st, status_out);
        chk("data_addr", (st & 'h20) << 2 | dv, data_addr);
        @(posedge clk);
    endtask

    // Main sequence
    initial begin
        logic [7:0] a;
        logic [7:0] b;
        int         k;
        int         dv;
        logic [7:0] wv [4] = '{8'h00, 8'h3F, 8'h00, 8'h25};
        logic [3:0] wa [4] = '{4'h0, 4'h0, 4'h4, 4'h8};
        srst = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
        dir_addr = 7'h00;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_all();
        for (k = 0; k < 4; k++) begin
            wb(1'b1, wa[k], wv[k]);
            rd_all();
        end
        $display("register access test done");
        for (k = 0; k < 60; k++) begin
            a = 8'(rnd());
            b = 8'(rnd());
            dv = rnd() & 127;
            if (k & 1) a = a & 8'h3F;
            dir_addr <= 7'(dv);
            run(csf_pkg::csf_op_t'(1 + k % 10), a, b, 1'(k & 1), dv);
        end
        $display("instruction flag test done");
        for (k = 1; k < 8; k++) begin
            u_core.pulse(3'(k));
            if (k & 4) st = st | 'h18;
            if (k & 2) st = st & 'hF7 | 'h10;
            if (k & 1) st = st & 'hEF;
            @(posedge clk);
            #1;
            chk("status_out", st, status_out);
            @(posedge clk);
        end
        $display("watchdog and sleep test done");
        conclude();
    end
endmodule
`default_nettype wire
